// ---- serial_port_pkg.sv ----
package serial_port_pkg;
   localparam int DATA_W        = 8;
   localparam int WORD4_BITS    = 8;
   localparam int WORD3_BITS    = 9;
   localparam int FIFO_DEPTH    = 8;
   localparam int SYS_CLK_MHZ   = 40;
   // strap levels
   localparam logic STRAP_FOUR_WIRE  = 1'b0;
   localparam logic STRAP_THREE_WIRE = 1'b1;
   // flag levels
   localparam logic FLAG_DATA    = 1'b1;
   localparam logic FLAG_COMMAND = 1'b0;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;

   typedef struct packed {
      logic              is_data;
      logic [DATA_W-1:0] value;
   } rx_word_s;

   localparam int WORD_W = DATA_W + 1;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DROP  = 2'b10
   } rx_state_e;
endpackage : serial_port_pkg

// ---- word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   always_comb begin
      push        = in_valid && (count != DEPTH[AW:0]);
      pop         = out_ready && (count != '0);
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         // empty after reset, so room is there from the first edge on
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= (next_count != DEPTH[AW:0]);
         // registered read port: head word stands while out_valid and not popped
         out_valid <= (next_count != '0);
         out_data  <= mem[next_rd_ptr];
         if (push && next_wr_ptr != next_rd_ptr) begin
            out_data <= mem[next_rd_ptr];
         end
         if (push && (next_count == 1) ) begin
            out_data <= in_data;
         end else if (push && (wr_ptr == next_rd_ptr)) begin
            out_data <= in_data;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : word_fifo

// ---- display_serial_write_port.sv ----
`timescale 1ns/1ps
module display_serial_write_port
   import serial_port_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // system
   input  wire logic                          sys_clk,
   input  wire logic                          resetn,
   // host pins
   input  wire logic                          reset_in_n,
   input  wire logic                          chip_select_n,
   input  wire logic                          serial_clk,
   input  wire logic                          serial_data_in,
   input  wire logic                          data_cmd_sel,
   input  wire logic                          bus_mode_strap,
   output logic                               busy_out_n,
   // busy sources inside the controller
   input  wire logic                          waveform_active,
   input  wire logic                          otp_program_active,
   input  wire logic                          temp_sensor_active,
   // received words toward ram and command register
   output logic                               ram_write,
   output logic                               cmd_write,
   output logic [serial_port_pkg::DATA_W-1:0] write_byte,
   input  wire logic                          sink_ready,
   // back-pressure indication
   output logic                               fifo_full
);
   // two-flop synchronisers for all pin inputs
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       sclk_prev;
   logic       reset_in_n_s;
   logic       cs_n_s;
   logic       sclk_s;
   logic       serial_data_in_s;
   logic       dc_s;
   logic       strap_s;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         // idle pin levels: no false clock edge or frame right after reset
         sync1     <= 6'h30;
         sync2     <= 6'h30;
         sclk_prev <= 1'b0;
      end else begin
         sync1     <= {reset_in_n, chip_select_n, serial_clk,
                       serial_data_in, data_cmd_sel, bus_mode_strap};
         sync2     <= sync1;
         sclk_prev <= sync2[3];
      end
   end

   always_comb begin
      reset_in_n_s = sync2[5];
      cs_n_s       = sync2[4];
      sclk_s       = sync2[3];
      serial_data_in_s       = sync2[2];
      dc_s         = sync2[1];
      strap_s      = sync2[0];
   end

   // receive state
   rx_state_e         state;
   rx_state_e         next_state;
   logic [3:0]        bit_cnt;
   logic [3:0]        next_bit_cnt;
   logic [DATA_W-1:0] shift;
   logic [DATA_W-1:0] next_shift;
   logic              flag;
   logic              next_flag;
   logic              three_wire;
   logic              next_three_wire;
   logic              push;
   logic              next_push;
   rx_word_s          push_word;
   rx_word_s          next_push_word;
   logic              rise;
   logic [3:0]        last_bit;
   logic              fifo_in_ready;

   always_comb begin
      rise            = sclk_s && !sclk_prev;
      last_bit        = three_wire ? 4'(WORD3_BITS - 1) : 4'(WORD4_BITS - 1);
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_flag       = flag;
      next_three_wire = three_wire;
      next_push       = 1'b0;
      next_push_word  = push_word;
      case (state)
         ST_IDLE: begin
            if (!cs_n_s) begin
               // mode latched per frame so a moving strap cannot split a word
               next_three_wire = (strap_s == STRAP_THREE_WIRE);
               next_bit_cnt    = BIT_CNT_RESET;
               next_state      = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (cs_n_s) begin
               // partial word dropped, counting restarts next frame
               next_bit_cnt = BIT_CNT_RESET;
               next_state   = ST_IDLE;
            end else if (rise) begin
               if (three_wire && bit_cnt == BIT_CNT_RESET) begin
                  next_flag = serial_data_in_s;
               end else begin
                  next_shift = {shift[DATA_W-2:0], serial_data_in_s};
               end
               if (bit_cnt == last_bit) begin
                  next_bit_cnt = BIT_CNT_RESET;
                  if (fifo_in_ready) begin
                     next_push           = 1'b1;
                     next_push_word.value = {shift[DATA_W-2:0], serial_data_in_s};
                     // four-wire samples the pin on the last clock
                     next_push_word.is_data = three_wire ? flag : dc_s;
                  end else begin
                     // no room: rest of frame ignored rather than corrupting order
                     next_state = ST_DROP;
                  end
               end else begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
         end
         ST_DROP: begin
            if (cs_n_s) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // external reset pin returns the receiver to ST_IDLE and cancels a push; FIFO and outputs keep their state
      if (!reset_in_n_s) begin
         next_state   = ST_IDLE;
         next_bit_cnt = BIT_CNT_RESET;
         next_push    = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state      <= ST_IDLE;
         bit_cnt    <= BIT_CNT_RESET;
         shift      <= '0;
         flag       <= FLAG_COMMAND;
         three_wire <= 1'b0;
         push       <= 1'b0;
         push_word  <= '0;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         flag       <= next_flag;
         three_wire <= next_three_wire;
         push       <= next_push;
         push_word  <= next_push_word;
      end
   end

   // word buffer; no read path back to the host exists
   logic             fifo_out_valid;
   logic             fifo_pop;
   logic [WORD_W-1:0] fifo_out_data;
   rx_word_s         head;

   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // drain side outputs
   logic              next_ram_write;
   logic              next_cmd_write;
   logic [DATA_W-1:0] next_write_byte;
   logic              next_busy_out_n;

   always_comb begin
      head            = rx_word_s'(fifo_out_data);
      fifo_pop        = fifo_out_valid && sink_ready && !ram_write && !cmd_write;
      next_ram_write  = fifo_pop && (head.is_data == FLAG_DATA);
      next_cmd_write  = fifo_pop && (head.is_data == FLAG_COMMAND);
      next_write_byte = fifo_pop ? head.value : write_byte;
      next_busy_out_n = !(waveform_active || otp_program_active
                          || temp_sensor_active);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ram_write  <= 1'b0;
         cmd_write  <= 1'b0;
         write_byte <= '0;
         busy_out_n <= 1'b0;
         fifo_full  <= 1'b0;
      end else begin
         ram_write  <= next_ram_write;
         cmd_write  <= next_cmd_write;
         write_byte <= next_write_byte;
         busy_out_n <= next_busy_out_n;
         fifo_full  <= !fifo_in_ready;
      end
   end
endmodule : display_serial_write_port

// ---- display_serial_write_port_props.sv ----
`timescale 1ns/1ps
module display_serial_write_port_props
   import serial_port_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // system
   input wire logic              sys_clk,
   input wire logic              resetn,
   // busy
   input wire logic              busy_out_n,
   input wire logic              waveform_active,
   input wire logic              otp_program_active,
   input wire logic              temp_sensor_active,
   // sink side
   input wire logic              ram_write,
   input wire logic              cmd_write,
   input wire logic [DATA_W-1:0] write_byte,
   input wire logic              sink_ready,
   input wire logic              fifo_full
);
   logic any_busy;
   logic any_write;
   assign any_busy  = waveform_active | otp_program_active | temp_sensor_active;
   assign any_write = ram_write | cmd_write;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   busy_low_a: assert property (any_busy |=> !busy_out_n)
      else $error("busy stayed high");
   busy_high_a: assert property (!any_busy |=> busy_out_n)
      else $error("busy low without cause");
   busy_cause_a: assert property ($fell(busy_out_n) |-> $past(any_busy))
      else $error("busy fell without source");
   write_excl_a: assert property (!(ram_write && cmd_write))
      else $error("ram and command write together");
   write_gap_a: assert property (any_write |=> !any_write)
      else $error("write pulses back to back");
   write_gate_a: assert property (any_write |-> $past(sink_ready))
      else $error("write while sink stalled");
   byte_hold_a: assert property ($changed(write_byte) |-> any_write)
      else $error("byte changed without write");
   full_hold_a: assert property (fifo_full && !sink_ready |=> fifo_full)
      else $error("full cleared without drain");
   cover property (ram_write);
   cover property (cmd_write);
   cover property (fifo_full);
   cover property ($fell(busy_out_n));
endmodule : display_serial_write_port_props

bind display_serial_write_port display_serial_write_port_props #(.DEPTH(DEPTH)) u_props (
   .sys_clk(sys_clk), .resetn(resetn), .busy_out_n(busy_out_n),
   .waveform_active(waveform_active), .otp_program_active(otp_program_active),
   .temp_sensor_active(temp_sensor_active), .ram_write(ram_write), .cmd_write(cmd_write),
   .write_byte(write_byte), .sink_ready(sink_ready), .fifo_full(fifo_full));

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model (
   // serial pins toward the display
   output logic chip_select_n,
   output logic serial_clk,
   output logic serial_data_in,
   output logic data_cmd_sel
);
   initial begin
      chip_select_n  = 1'b1;
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
      data_cmd_sel   = 1'b0;
   end
   // one word per frame; nbits below the word size aborts it early
   task automatic send(input logic three, input logic is_data, input logic [7:0] b,
                       input int nbits);
      logic [8:0] w;
      int         i;
      w = {is_data, b};
      #37;
      chip_select_n = 1'b0;
      data_cmd_sel  = three ? 1'b0 : is_data;
      #150;
      for (i = three ? 8 : 7; i >= 0 && nbits > 0; i--) begin
         serial_data_in = w[i];
         #100 serial_clk = 1'b1;
         #100 serial_clk = 1'b0;
         nbits--;
      end
      #150;
      chip_select_n = 1'b1;
      // released line must not look like the last bit
      serial_data_in = ~serial_data_in;
   endtask : send
endmodule : host_model

// ---- display_serial_write_port_test.sv ----
`timescale 1ns/1ps
module display_serial_write_port_test;
   import serial_port_pkg::*;
   logic              sys_clk = 0, resetn = 0, reset_in_n = 0, strap = 0, sink_ready = 1;
   logic [2:0]        src = 0;
   logic              chip_select_n, serial_clk, serial_data_in, data_cmd_sel;
   logic              busy_out_n, ram_write, cmd_write, fifo_full;
   logic [DATA_W-1:0] write_byte;
   logic [WORD_W-1:0] got[$];
   // {three wire, is data, byte}
   logic [WORD_W:0]   rows[4] = '{10'h1A5, 10'h03C, 10'h381, 10'h27E};
   int                errors = 0, n_checks = 0, i;

   always #12.5 sys_clk = ~sys_clk;
   host_model u_host_model (.chip_select_n(chip_select_n), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .data_cmd_sel(data_cmd_sel));
   display_serial_write_port u_display_serial_write_port (.sys_clk(sys_clk),
      .resetn(resetn), .reset_in_n(reset_in_n), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_data_in(serial_data_in),
      .data_cmd_sel(data_cmd_sel), .bus_mode_strap(strap), .busy_out_n(busy_out_n),
      .waveform_active(src[0]), .otp_program_active(src[1]),
      .temp_sensor_active(src[2]), .ram_write(ram_write), .cmd_write(cmd_write),
      .write_byte(write_byte), .sink_ready(sink_ready), .fifo_full(fifo_full));

   always @(negedge sys_clk) if (ram_write || cmd_write) got.push_back({ram_write, write_byte});

   task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task expect_word(input logic [WORD_W-1:0] exp);
      int k;
      for (k = 0; k < 200 && got.size() == 0; k++) @(posedge sys_clk);
      check(got.size() > 0 ? got.pop_front() : 'x, exp);
   endtask : expect_word
   task settle_empty;
      repeat (60) @(negedge sys_clk);
      check(WORD_W'(got.size()), '0);
   endtask : settle_empty
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   initial begin
      #100000;
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(negedge sys_clk);
      resetn = 1;
      reset_in_n = 1;
      repeat (4) @(negedge sys_clk);
      for (i = 0; i < 4; i++) begin
         wait (busy_out_n === 1'b1);
         @(negedge sys_clk) strap = rows[i][9];
         u_host_model.send(rows[i][9], rows[i][8], rows[i][7:0], 9);
         expect_word(rows[i][8:0]);
      end
      $display("table done");
      @(negedge sys_clk) strap = STRAP_FOUR_WIRE;
      u_host_model.send(0, 1, 8'h11, 5);
      u_host_model.send(0, 0, 8'h96, 8);
      expect_word(9'h096);
      settle_empty();
      $display("partial word done");
      fork
         u_host_model.send(0, 1, 8'hF0, 8);
         begin
            #700 @(negedge sys_clk) reset_in_n = 0;
            repeat (6) @(negedge sys_clk);
            reset_in_n = 1;
         end
      join
      settle_empty();
      $display("host reset done");
      for (i = 0; i < 3; i++) begin
         @(negedge sys_clk) src = 3'b001 << i;
         repeat (2) @(negedge sys_clk);
         check(WORD_W'(busy_out_n), '0);
         src = 0;
         repeat (2) @(negedge sys_clk);
         check(WORD_W'(busy_out_n), 9'h001);
      end
      $display("busy done");
      @(negedge sys_clk) sink_ready = 0;
      for (i = 0; i < 9; i++) u_host_model.send(0, 1, 8'(8'h40 + i), 8);
      repeat (10) @(negedge sys_clk);
      check({WORD_W'(got.size()), fifo_full}, 10'h001);
      sink_ready = 1;
      for (i = 0; i < 8; i++) expect_word({1'b1, 8'(8'h40 + i)});
      settle_empty();
      $display("fill done");
      @(negedge sys_clk) resetn = 0;
      repeat (2) @(negedge sys_clk);
      check({busy_out_n, ram_write, cmd_write, fifo_full}, '0);
      resetn = 1;
      $display("reset done");
      report_and_stop();
   end
endmodule : display_serial_write_port_test
